/* File: verilog/multipin_consts.vh */
// constants for the multifunction pin control and status block
`ifndef MULTIPIN_CONSTS_VH
`define MULTIPIN_CONSTS_VH

// register indices (byte address is four times the index)
`define MPIN_CFG_FIRST_IDX 16'h0102
`define MPIN_CFG_LAST_IDX 16'h0108
`define MPIN_CMD_VIEW_IDX 16'h0110
`define MPIN_PIN_VIEW_IDX 16'h0111
`define MPIN_CFG_RESET 8'h00

// pin configuration fields
`define MPIN_DIR_BIT 7
`define MPIN_CODE_MSB 6

// pin count and command count
`define MPIN_NUM_PINS 7
`define MPIN_NUM_CMDS 28

// status function codes
`define STAT_LOW 7'h00
`define STAT_HIGH 7'h01
`define STAT_SYSCLK_DIV 7'h02
`define STAT_WDOG 7'h03
`define STAT_PLL_CAL 7'h04
`define STAT_PLL_LOCK 7'h05
`define STAT_PLL_STABLE 7'h06

// control function codes, channel 0
`define CTL_CH0_A_MUTE_T 7'h50
`define CTL_CH0_A_MUTE_C 7'h51
`define CTL_CH0_A_RESET 7'h52
`define CTL_CH0_B_MUTE_T 7'h53
`define CTL_CH0_B_MUTE_C 7'h54
`define CTL_CH0_B_RESET 7'h55
`define CTL_CH0_C_MUTE_T 7'h56
`define CTL_CH0_C_MUTE_C 7'h57
`define CTL_CH0_C_RESET 7'h58
`define CTL_CH0_MUTE_ALL 7'h59
`define CTL_CH0_RESET_ALL 7'h5A
`define CTL_CH0_NSHOT 7'h5B
// control function codes, channel 1
`define CTL_CH1_PWRDN 7'h60
`define CTL_CH1_FREERUN 7'h61
`define CTL_CH1_HOLDOVER 7'h62
`define CTL_CH1_CLR_HIST 7'h63
`define CTL_CH1_SYNC 7'h64
`define CTL_CH1_PROF0 7'h65
`define CTL_CH1_PROF1 7'h66
`define CTL_CH1_PROF2 7'h67
`define CTL_CH1_A_MUTE_T 7'h70
`define CTL_CH1_A_MUTE_C 7'h71
`define CTL_CH1_A_RESET 7'h72
`define CTL_CH1_B_MUTE_T 7'h73
`define CTL_CH1_B_MUTE_C 7'h74
`define CTL_CH1_B_RESET 7'h75
`define CTL_CH1_MUTE_ALL 7'h76
`define CTL_CH1_RESET_ALL 7'h77

// timing counts in system clock periods
`define SYSCLK_DIV_CYCLES 7'd96
`define SYSCLK_DIV_HALF 7'd48
`define WDOG_STROBE_CYCLES 7'd96

`endif

/* File: verilog/multipin_ctrl.v */
// multifunction pin control and status logic with apb register access
`timescale 1ns/1ps
`include "multipin_consts.vh"

module multipin_ctrl (
    input wire mclk_i,
    input wire rstn_i,
    // apb slave
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [15:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire [3:0] pstrb_i,
    output wire [31:0] prdata_o,
    output wire pready_o,
    output wire pslverr_o,
    // multifunction pins, three signals each
    input wire [6:0] multifunction_pin_i,
    output wire [6:0] multifunction_pin_o,
    output wire [6:0] multifunction_pin_oe_o,
    // live status sources, same clock
    input wire wdog_expire_i,
    input wire sysclk_pll_cal_i,
    input wire sysclk_pll_lock_i,
    input wire sysclk_pll_stable_i,
    // channel 0 commands
    output wire ch0_pair_a_true_mute_o,
    output wire ch0_pair_a_comp_mute_o,
    output wire ch0_pair_a_reset_o,
    output wire ch0_pair_b_true_mute_o,
    output wire ch0_pair_b_comp_mute_o,
    output wire ch0_pair_b_reset_o,
    output wire ch0_pair_c_true_mute_o,
    output wire ch0_pair_c_comp_mute_o,
    output wire ch0_pair_c_reset_o,
    output wire ch0_mute_all_o,
    output wire ch0_reset_all_o,
    output wire ch0_nshot_req_o,
    // channel 1 commands
    output wire ch1_power_down_o,
    output wire ch1_digital_loop_freerun_o,
    output wire ch1_digital_loop_holdover_o,
    output wire ch1_digital_loop_clr_hist_o,
    output wire ch1_sync_dividers_o,
    output wire ch1_profile_sel0_o,
    output wire ch1_profile_sel1_o,
    output wire ch1_profile_sel2_o,
    output wire ch1_pair_a_true_mute_o,
    output wire ch1_pair_a_comp_mute_o,
    output wire ch1_pair_a_reset_o,
    output wire ch1_pair_b_true_mute_o,
    output wire ch1_pair_b_comp_mute_o,
    output wire ch1_pair_b_reset_o,
    output wire ch1_mute_all_o,
    output wire ch1_reset_all_o
);

    // control code belonging to each command bit
    function [6:0] cmd_code;
        input integer k;
        begin
            case (k)
                0: cmd_code = `CTL_CH0_A_MUTE_T;
                1: cmd_code = `CTL_CH0_A_MUTE_C;
                2: cmd_code = `CTL_CH0_A_RESET;
                3: cmd_code = `CTL_CH0_B_MUTE_T;
                4: cmd_code = `CTL_CH0_B_MUTE_C;
                5: cmd_code = `CTL_CH0_B_RESET;
                6: cmd_code = `CTL_CH0_C_MUTE_T;
                7: cmd_code = `CTL_CH0_C_MUTE_C;
                8: cmd_code = `CTL_CH0_C_RESET;
                9: cmd_code = `CTL_CH0_MUTE_ALL;
                10: cmd_code = `CTL_CH0_RESET_ALL;
                11: cmd_code = `CTL_CH0_NSHOT;
                12: cmd_code = `CTL_CH1_PWRDN;
                13: cmd_code = `CTL_CH1_FREERUN;
                14: cmd_code = `CTL_CH1_HOLDOVER;
                15: cmd_code = `CTL_CH1_CLR_HIST;
                16: cmd_code = `CTL_CH1_SYNC;
                17: cmd_code = `CTL_CH1_PROF0;
                18: cmd_code = `CTL_CH1_PROF1;
                19: cmd_code = `CTL_CH1_PROF2;
                20: cmd_code = `CTL_CH1_A_MUTE_T;
                21: cmd_code = `CTL_CH1_A_MUTE_C;
                22: cmd_code = `CTL_CH1_A_RESET;
                23: cmd_code = `CTL_CH1_B_MUTE_T;
                24: cmd_code = `CTL_CH1_B_MUTE_C;
                25: cmd_code = `CTL_CH1_B_RESET;
                26: cmd_code = `CTL_CH1_MUTE_ALL;
                27: cmd_code = `CTL_CH1_RESET_ALL;
                // unused index never matches a valid code
                default: cmd_code = 7'h7F;
            endcase
        end
    endfunction

    // byte address of a register index
    function [15:0] idx_addr;
        input [15:0] idx;
        begin
            idx_addr = {idx[13:0], 2'b00};
        end
    endfunction

    // configuration bytes, one per pin
    reg [7:0] cfg_q [0:6];
    // three stage pin synchronisers
    reg [6:0] pin_s1_q;
    reg [6:0] pin_s2_q;
    reg [6:0] pin_s3_q;
    // debounced pin level
    reg [6:0] pin_lvl_q;
    // pin drivers
    reg [6:0] pin_out_q;
    reg [6:0] pin_oe_q;
    // command bits toward the clock core
    reg [27:0] cmd_q;
    reg [27:0] cmd_d;
    // divided clock counter and output
    reg [6:0] div_cnt_q;
    reg div_clk_q;
    // watchdog strobe counter
    reg [6:0] wdog_cnt_q;
    // apb answer registers
    reg pready_q;
    reg pslverr_q;
    reg [31:0] prdata_q;
    // read mux next values
    reg [31:0] rdata_d;
    reg hit_d;
    reg [6:0] stat_d;
    // loop indices, none shared between processes so no variable has two drivers
    integer p_sync;
    integer p_dec;
    integer p_drv;
    integer p_cfg;
    integer p_rd;
    integer k;

    // access phase and write strobe
    wire apb_acc = psel_i & penable_i;
    wire apb_wr = apb_acc & pready_q & pwrite_i & pstrb_i[0] & ~pslverr_q;
    wire wdog_strobe = (wdog_cnt_q != 7'd0);

    // pin synchroniser; a level counts once stages two and three agree
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pin_s1_q <= 7'h00;
            pin_s2_q <= 7'h00;
            pin_s3_q <= 7'h00;
            pin_lvl_q <= 7'h00;
        end else begin
            pin_s1_q <= multifunction_pin_i;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            for (p_sync = 0; p_sync < `MPIN_NUM_PINS; p_sync = p_sync + 1) begin
                if (pin_s2_q[p_sync] == pin_s3_q[p_sync]) begin
                    pin_lvl_q[p_sync] <= pin_s3_q[p_sync];
                end
            end
        end
    end

    // command decode: or of every input pin carrying the code
    always @* begin
        cmd_d = 28'h0000000;
        for (k = 0; k < `MPIN_NUM_CMDS; k = k + 1) begin
            for (p_dec = 0; p_dec < `MPIN_NUM_PINS; p_dec = p_dec + 1) begin
                // pin level stands in for the bit
                if (!cfg_q[p_dec][`MPIN_DIR_BIT] && pin_lvl_q[p_dec] &&
                    cfg_q[p_dec][`MPIN_CODE_MSB:0] == cmd_code(k)) begin
                    cmd_d[k] = 1'b1;
                end
            end
        end
    end

    // command register
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cmd_q <= 28'h0000000;
        end else begin
            cmd_q <= cmd_d;
        end
    end

    // divided system clock, free running
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            div_cnt_q <= 7'd0;
            div_clk_q <= 1'b0;
        end else begin
            // wrap at 96, high for the first half
            if (div_cnt_q == `SYSCLK_DIV_CYCLES - 7'd1) begin
                div_cnt_q <= 7'd0;
            end else begin
                div_cnt_q <= div_cnt_q + 7'd1;
            end
            div_clk_q <= (div_cnt_q < `SYSCLK_DIV_HALF);
        end
    end

    // watchdog strobe stretcher
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wdog_cnt_q <= 7'd0;
        end else if (wdog_expire_i) begin
            wdog_cnt_q <= `WDOG_STROBE_CYCLES;
        end else if (wdog_strobe) begin
            wdog_cnt_q <= wdog_cnt_q - 7'd1;
        end
    end

    // pin drivers, live selected status every clock
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pin_out_q <= 7'h00;
            pin_oe_q <= 7'h00;
        end else begin
            for (p_drv = 0; p_drv < `MPIN_NUM_PINS; p_drv = p_drv + 1) begin
                pin_oe_q[p_drv] <= cfg_q[p_drv][`MPIN_DIR_BIT];
                // no commit strobe, sampled each clock
                case (cfg_q[p_drv][`MPIN_CODE_MSB:0])
                    `STAT_LOW: pin_out_q[p_drv] <= 1'b0;
                    `STAT_HIGH: pin_out_q[p_drv] <= cfg_q[p_drv][`MPIN_DIR_BIT];
                    `STAT_SYSCLK_DIV: pin_out_q[p_drv] <=
                        cfg_q[p_drv][`MPIN_DIR_BIT] & div_clk_q;
                    `STAT_WDOG: pin_out_q[p_drv] <=
                        cfg_q[p_drv][`MPIN_DIR_BIT] & wdog_strobe;
                    `STAT_PLL_CAL: pin_out_q[p_drv] <=
                        cfg_q[p_drv][`MPIN_DIR_BIT] & sysclk_pll_cal_i;
                    `STAT_PLL_LOCK: pin_out_q[p_drv] <=
                        cfg_q[p_drv][`MPIN_DIR_BIT] & sysclk_pll_lock_i;
                    `STAT_PLL_STABLE: pin_out_q[p_drv] <=
                        cfg_q[p_drv][`MPIN_DIR_BIT] & sysclk_pll_stable_i;
                    // unsupported codes drive low
                    default: pin_out_q[p_drv] <= 1'b0;
                endcase
            end
        end
    end

    // configuration writes
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (p_cfg = 0; p_cfg < `MPIN_NUM_PINS; p_cfg = p_cfg + 1) begin
                cfg_q[p_cfg] <= `MPIN_CFG_RESET;
            end
        end else if (apb_wr) begin
            for (p_cfg = 0; p_cfg < `MPIN_NUM_PINS; p_cfg = p_cfg + 1) begin
                if (paddr_i == idx_addr(`MPIN_CFG_FIRST_IDX + p_cfg[15:0])) begin
                    cfg_q[p_cfg] <= pwdata_i[7:0];
                end
            end
        end
    end

    // read mux and address decode
    always @* begin
        rdata_d = 32'h00000000;
        hit_d = 1'b0;
        stat_d = 7'h00;
        for (p_rd = 0; p_rd < `MPIN_NUM_PINS; p_rd = p_rd + 1) begin
            if (paddr_i == idx_addr(`MPIN_CFG_FIRST_IDX + p_rd[15:0])) begin
                rdata_d = {24'h000000, cfg_q[p_rd]};
                hit_d = 1'b1;
            end
        end
        if (paddr_i == idx_addr(`MPIN_CMD_VIEW_IDX)) begin
            // live command bits, read only
            rdata_d = {4'h0, cmd_q};
            hit_d = !pwrite_i;
        end
        if (paddr_i == idx_addr(`MPIN_PIN_VIEW_IDX)) begin
            // debounced pin levels and driven values, read only
            stat_d = pin_lvl_q;
            rdata_d = {9'h000, pin_oe_q, 1'b0, pin_out_q, 1'b0, stat_d};
            hit_d = !pwrite_i;
        end
    end

    // apb answer: one wait state, error on unmapped or read only write
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end else if (apb_acc && !pready_q) begin
            pready_q <= 1'b1;
            pslverr_q <= ~hit_d;
            prdata_q <= (hit_d && !pwrite_i) ? rdata_d : 32'h00000000;
        end else begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end
    end

    // outputs straight from flops
    assign prdata_o = prdata_q;
    assign pready_o = pready_q;
    assign pslverr_o = pslverr_q;
    assign multifunction_pin_o = pin_out_q;
    assign multifunction_pin_oe_o = pin_oe_q;
    assign ch0_pair_a_true_mute_o = cmd_q[0];
    assign ch0_pair_a_comp_mute_o = cmd_q[1];
    assign ch0_pair_a_reset_o = cmd_q[2];
    assign ch0_pair_b_true_mute_o = cmd_q[3];
    assign ch0_pair_b_comp_mute_o = cmd_q[4];
    assign ch0_pair_b_reset_o = cmd_q[5];
    assign ch0_pair_c_true_mute_o = cmd_q[6];
    assign ch0_pair_c_comp_mute_o = cmd_q[7];
    assign ch0_pair_c_reset_o = cmd_q[8];
    assign ch0_mute_all_o = cmd_q[9];
    assign ch0_reset_all_o = cmd_q[10];
    assign ch0_nshot_req_o = cmd_q[11];
    assign ch1_power_down_o = cmd_q[12];
    assign ch1_digital_loop_freerun_o = cmd_q[13];
    assign ch1_digital_loop_holdover_o = cmd_q[14];
    assign ch1_digital_loop_clr_hist_o = cmd_q[15];
    assign ch1_sync_dividers_o = cmd_q[16];
    assign ch1_profile_sel0_o = cmd_q[17];
    assign ch1_profile_sel1_o = cmd_q[18];
    assign ch1_profile_sel2_o = cmd_q[19];
    assign ch1_pair_a_true_mute_o = cmd_q[20];
    assign ch1_pair_a_comp_mute_o = cmd_q[21];
    assign ch1_pair_a_reset_o = cmd_q[22];
    assign ch1_pair_b_true_mute_o = cmd_q[23];
    assign ch1_pair_b_comp_mute_o = cmd_q[24];
    assign ch1_pair_b_reset_o = cmd_q[25];
    assign ch1_mute_all_o = cmd_q[26];
    assign ch1_reset_all_o = cmd_q[27];

endmodule

/* File: testbench/multipin_chk.sv */
// assertion checker for the multifunction pin block
`timescale 1ns/1ps
module multipin_chk (
    input wire mclk_i,
    input wire rstn_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [15:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire [3:0] pstrb_i,
    input wire [31:0] prdata_o,
    input wire pready_o,
    input wire pslverr_o,
    input wire [6:0] multifunction_pin_i,
    input wire [6:0] multifunction_pin_o,
    input wire [6:0] multifunction_pin_oe_o,
    input wire sysclk_pll_lock_i,
    input wire ch0_pair_a_true_mute_o,
    input wire ch1_reset_all_o
);
    logic [7:0] cfg_q; // shadow of pin 0 config
    logic [6:0] run_q; // high run on pin 0
    logic [3:0] age_q; // cycles since a pin was high
    wire hit = psel_i && penable_i && pready_o;
    wire cmd = ch0_pair_a_true_mute_o || ch1_reset_all_o;
    // shadow follows completed writes, counters saturate
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cfg_q <= 8'h00;
            run_q <= 7'h00;
            age_q <= 4'hF;
        end else begin
            if (hit && pwrite_i && pstrb_i[0] && paddr_i == 16'h0408) begin
                cfg_q <= pwdata_i[7:0];
            end
            run_q <= multifunction_pin_o[0] ? run_q + {6'h0, run_q != 7'h7F} : 7'h00;
            age_q <= (|multifunction_pin_i) ? 4'h0 : age_q + {3'h0, age_q != 4'hF};
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    sequence cfg_still;
        $stable(cfg_q) ##1 $stable(cfg_q);
    endsequence
    sequence access_start;
        psel_i && $rose(penable_i);
    endsequence
    a_ready_wait: assert property (access_start |-> !pready_o ##1 pready_o)
        else $error("pready not after one wait");
    a_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("pready longer than one cycle");
    a_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h0)
        else $error("read data outside answer");
    a_unmapped_err: assert property (hit && paddr_i == 16'h0500 |-> pslverr_o)
        else $error("unmapped access not refused");
    a_undriven_low: assert property ((multifunction_pin_o & ~multifunction_pin_oe_o) == 7'h0)
        else $error("pin value without enable");
    a_dir_to_oe: assert property (cfg_still |-> multifunction_pin_oe_o[0] == cfg_q[7])
        else $error("enable differs from direction");
    a_static_level: assert property (cfg_still ##0 (cfg_q[7:1] == 7'h40)
        |-> multifunction_pin_o[0] == cfg_q[0])
        else $error("static level wrong");
    a_lock_mirror: assert property (cfg_still ##0 (cfg_q == 8'h85)
        |-> multifunction_pin_o[0] == $past(sysclk_pll_lock_i))
        else $error("lock not mirrored");
    a_div_bound: assert property (cfg_q == 8'h82 |-> run_q <= 7'd48)
        else $error("divided clock high too long");
    a_wdog_len: assert property (cfg_q == 8'h83 && $fell(multifunction_pin_o[0])
        |-> run_q == 7'd96)
        else $error("watchdog strobe length wrong");
    a_cmd_cause: assert property (cmd |-> age_q <= 4'd7)
        else $error("command without pin request");
    a_cmd_release: assert property (age_q >= 4'd9 |-> !cmd)
        else $error("command stuck after release");
endmodule
bind multipin_ctrl multipin_chk multipin_chk_inst (.mclk_i, .rstn_i, .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .prdata_o, .pready_o, .pslverr_o,
    .multifunction_pin_i, .multifunction_pin_o, .multifunction_pin_oe_o,
    .sysclk_pll_lock_i, .ch0_pair_a_true_mute_o, .ch1_reset_all_o);

/* File: testbench/board_model.sv */
// board controller that requests functions on input pins
`timescale 1ns/1ps
module board_model (
    input wire [6:0] req_i,
    input wire [6:0] dev_o_i,
    input wire [6:0] dev_oe_i,
    output wire [6:0] wire_o
);
    // board drives request level where device does not drive
    assign wire_o = (dev_oe_i & dev_o_i) | (~dev_oe_i & req_i);
endmodule

/* File: testbench/multipin_tb.sv */
// self-checking testbench for the multifunction pin block
`timescale 1ns/1ps
module multifunction_pin_control_status_tb_top;
    logic mclk_i = 0, rstn_i = 0, psel = 0, pen = 0, pwr = 0, wdog = 0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0;
    logic [6:0] req = 7'h00; // board requests
    logic [2:0] src = 3'h0; // pll stable, lock, cal
    wire [31:0] prdata;
    wire pready, perr;
    wire [6:0] pin_i, pin_o, pin_oe;
    wire [27:0] cmd; // commands in code order
    int fails = 0, cmp_count = 0, ticks = 0;
    always #5 mclk_i = ~mclk_i;
    multipin_ctrl multipin_ctrl_inst (.mclk_i(mclk_i), .rstn_i(rstn_i), .psel_i(psel),
        .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hF),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(perr), .multifunction_pin_i(pin_i),
        .multifunction_pin_o(pin_o), .multifunction_pin_oe_o(pin_oe), .wdog_expire_i(wdog),
        .sysclk_pll_cal_i(src[0]), .sysclk_pll_lock_i(src[1]), .sysclk_pll_stable_i(src[2]),
        .ch0_pair_a_true_mute_o(cmd[0]), .ch0_pair_a_comp_mute_o(cmd[1]),
        .ch0_pair_a_reset_o(cmd[2]), .ch0_pair_b_true_mute_o(cmd[3]),
        .ch0_pair_b_comp_mute_o(cmd[4]), .ch0_pair_b_reset_o(cmd[5]),
        .ch0_pair_c_true_mute_o(cmd[6]), .ch0_pair_c_comp_mute_o(cmd[7]),
        .ch0_pair_c_reset_o(cmd[8]), .ch0_mute_all_o(cmd[9]), .ch0_reset_all_o(cmd[10]),
        .ch0_nshot_req_o(cmd[11]), .ch1_power_down_o(cmd[12]),
        .ch1_digital_loop_freerun_o(cmd[13]), .ch1_digital_loop_holdover_o(cmd[14]),
        .ch1_digital_loop_clr_hist_o(cmd[15]), .ch1_sync_dividers_o(cmd[16]),
        .ch1_profile_sel0_o(cmd[17]), .ch1_profile_sel1_o(cmd[18]),
        .ch1_profile_sel2_o(cmd[19]), .ch1_pair_a_true_mute_o(cmd[20]),
        .ch1_pair_a_comp_mute_o(cmd[21]), .ch1_pair_a_reset_o(cmd[22]),
        .ch1_pair_b_true_mute_o(cmd[23]), .ch1_pair_b_comp_mute_o(cmd[24]),
        .ch1_pair_b_reset_o(cmd[25]), .ch1_mute_all_o(cmd[26]), .ch1_reset_all_o(cmd[27]));
    board_model board_model_inst (.req_i(req), .dev_o_i(pin_o), .dev_oe_i(pin_oe),
        .wire_o(pin_i));
    task give_verdict;
        if (fails == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e, input string m);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    // one apb transfer, held until pready is sampled
    task apb(input logic w, input logic [15:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        @(posedge mclk_i);
        psel <= 1;
        pen <= 0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk_i);
        pen <= 1;
        // no cycle count assumed; this wait ends on pready, and the hang guard is its only timeout
        do begin
            @(posedge mclk_i);
        end while (pready !== 1'b1);
        r = prdata;
        e = perr;
        psel <= 0;
        pen <= 0;
    endtask
    task wr(input logic [15:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1, a, {24'h0, d}, r, e);
    endtask
    task stat(input logic [7:0] c, input logic x);
        wr(16'h0408, c);
        repeat (3) @(posedge mclk_i);
        chk({31'h0, pin_i[0]}, {31'h0, x}, "pin level");
    endtask
    task run_len(input logic lvl, output int n);
        n = 0;
        while (pin_i[0] === lvl && n < 300) begin
            @(posedge mclk_i);
            n++;
        end
    endtask
    // reset values, read back, refused address
    task t_regs;
        logic [31:0] r;
        logic e;
        for (int k = 0; k < 7; k++) begin
            apb(0, 16'h0408 + 16'(4 * k), 32'h0, r, e);
            chk(r, 32'h0, "config reset");
        end
        wr(16'h0420, 8'hA5);
        apb(0, 16'h0420, 32'h0, r, e);
        chk(r, 32'hA5, "config read back");
        wr(16'h0420, 8'h00);
        apb(1, 16'h0500, 32'hFF, r, e);
        chk({31'h0, e}, 32'h1, "unmapped write");
        apb(0, 16'h0500, 32'h0, r, e);
        chk({e, r[30:0]}, 32'h80000000, "unmapped read");
    endtask
    // every control code on an input pin
    task t_cmds;
        logic [31:0] r;
        logic e;
        logic [6:0] code;
        for (int i = 0; i < 28; i++) begin
            code = (i < 12) ? 7'h50 + 7'(i) : (i < 20) ? 7'h54 + 7'(i) : 7'h5C + 7'(i);
            wr(16'h0414, {1'b0, code});
            req[3] <= 1;
            repeat (8) @(posedge mclk_i);
            chk({4'h0, cmd}, 32'h1 << i, "command on");
            apb(0, 16'h0440, 32'h0, r, e);
            chk(r, 32'h1 << i, "command view");
            chk({25'h0, pin_oe}, 32'h0, "input pin driven");
            req[3] <= 0;
            repeat (8) @(posedge mclk_i);
            chk({4'h0, cmd}, 32'h0, "command off");
        end
        apb(1, 16'h0440, 32'h1, r, e);
        chk({31'h0, e}, 32'h1, "view write refused");
        // a requested pin with no command code drives nothing
        wr(16'h0414, 8'h68);
        req[3] <= 1;
        repeat (8) @(posedge mclk_i);
        chk({4'h0, cmd}, 32'h0, "unknown code");
        wr(16'h0414, 8'hD0);
        repeat (8) @(posedge mclk_i);
        chk({25'h0, pin_oe}, 32'h8, "output pin enable");
        chk({4'h0, cmd}, 32'h0, "output pin commands");
        req[3] <= 0;
        wr(16'h0414, 8'h00);
    endtask
    // mid-run reset clears configuration and drivers
    task t_reset;
        logic [31:0] r;
        logic e;
        stat(8'h81, 1);
        rstn_i <= 0;
        repeat (3) @(posedge mclk_i);
        chk({25'h0, pin_oe}, 32'h0, "driver in reset");
        rstn_i <= 1;
        apb(0, 16'h0408, 32'h0, r, e);
        chk(r, 32'h0, "config after reset");
        repeat (3) @(posedge mclk_i);
        chk({25'h0, pin_oe}, 32'h0, "driver after reset");
    endtask
    // status functions on pin 0
    task t_status;
        int n;
        stat(8'h80, 0);
        stat(8'h81, 1);
        stat(8'h00, 0);
        chk({25'h0, pin_oe}, 32'h0, "idle pin driven");
        for (int k = 0; k < 3; k++) begin
            src <= 3'b001 << k;
            stat(8'h84 + 8'(k), 1);
            src <= ~(3'b001 << k);
            repeat (3) @(posedge mclk_i);
            chk({31'h0, pin_i[0]}, 32'h0, "live status");
        end
        stat(8'h80, 0);
        wr(16'h0408, 8'h82);
        repeat (3) @(posedge mclk_i);
        run_len(1, n);
        run_len(0, n);
        run_len(1, n);
        chk(32'(n), 32'd48, "divided high");
        run_len(0, n);
        chk(32'(n), 32'd48, "divided low");
        stat(8'h80, 0);
        wr(16'h0408, 8'h83);
        repeat (3) @(posedge mclk_i);
        wdog <= 1;
        @(posedge mclk_i);
        wdog <= 0;
        run_len(0, n);
        run_len(1, n);
        chk(32'(n), 32'd96, "watchdog strobe");
        stat(8'h80, 0);
    endtask
    // hang guard
    always @(posedge mclk_i) begin
        ticks++;
        if (ticks == 20000) begin
            fails++;
            give_verdict;
        end
    end
    initial begin
        repeat (3) @(posedge mclk_i);
        rstn_i <= 1;
        t_regs;
        t_cmds;
        t_status;
        t_reset;
        give_verdict;
    end
endmodule
